//--- src/adc_serial_pkg.sv
// constants and state encoding for the converter serial interface
package adc_serial_pkg;
    localparam int             CLK_PERIOD_NS     = 10;
    localparam int             FRAME_BITS        = 32;
    localparam int             ADDR_BITS         = 8;
    localparam int             CNT_W             = 6;
    localparam int             DLY_W             = 12;
    localparam int             DIV_W             = 3;
    localparam int             POR_W             = 17;
    // serial clock is the conversion clock divided by eight
    localparam int             SCK_DIV           = 8;
    localparam logic [DIV_W-1:0] SCK_RISE_PH     = 3'h0;
    localparam logic [DIV_W-1:0] SCK_FALL_PH     = DIV_W'(SCK_DIV / 2);
    // status test delay, internal oscillator
    localparam int             TEST_INT_NS       = 23000;
    localparam logic [DLY_W-1:0] TEST_INT_CYC    =
        DLY_W'((TEST_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // status test delay, external oscillator: 3.6 periods
    localparam int             EXT_OSC_PERIOD_NS = 1000;
    localparam int             TEST_EXT_TENTHS   = 36;
    localparam logic [DLY_W-1:0] TEST_EXT_CYC    =
        DLY_W'((TEST_EXT_TENTHS * EXT_OSC_PERIOD_NS
                + 10 * CLK_PERIOD_NS - 1) / (10 * CLK_PERIOD_NS));
    // power-on reset window before the clock mode is caught
    localparam int             POR_NS            = 1000000;
    localparam int             POR_CYC           = POR_NS / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] ADDR_LAST       = CNT_W'(ADDR_BITS - 1);
    localparam logic [CNT_W-1:0] LAST_RISE       = CNT_W'(FRAME_BITS - 1);
    localparam logic [CNT_W-1:0] FRAME_END       = CNT_W'(FRAME_BITS);
    localparam logic [ADDR_BITS-1:0] CHAN_RESET  = 8'h00;
    localparam logic [DLY_W-1:0] DLY_ONE         = 12'h001;
    typedef enum logic [3:0] {
        ST_CONV  = 4'h1,
        ST_SLEEP = 4'h2,
        ST_TEST  = 4'h4,
        ST_DATA  = 4'h8
    } state_e;
endpackage : adc_serial_pkg

//--- src/adc_serial_timing_modes.sv
// serial result and channel-select interface with clock mode selection
// Functional notes
// R01: chip select fall samples clock line; low selects external clock mode.
// R02: clock high or floating at chip select fall selects internal mode.
// R03: data output released while chip select is high.
// R04: chip select low in convert or sleep shows busy flag, 1 or 0.
// R05: finished conversion always enters sleep, whatever chip select does; code enters status test instead in internal mode with chip select low.
// R06: sleep holds result until clock rises with chip select low.
// R07: input sampled on each rising edge, output updated on falling edges.
// R08: host takes flag on first rise and last bit on 32nd rise.
// R09: external clock: 32nd falling edge starts conversion, output goes high.
// R10: external clock: chip select rise mid-frame aborts, starts conversion.
// R11: chip select rise before last address bit keeps previous channel.
// R12: chip select tied low: clock mode caught at power-on reset end.
// R13: result loaded into shift register when busy flag falls.
// R14: internal mode: chip select low drives clock low, shows flag.
// R15: internal mode: clock starts after status test delay.
// R16: chip select rise within status test delay returns to sleep.
// R17: polling host raises chip select before first rise to stay idle.
// R18: internal mode: after 32nd rise output high, clock high, convert.
// R19: internal mode: chip select rise mid-frame aborts, starts conversion.
// R20: pull-up disabled while clock line low; low line means external.
// R21: chip select rise within status test delay re-enables pull-up.
// R22: internal serial clock is conversion clock divided by eight.
// R23: serial input ignored while chip select high or converting.
// R24: frame bit counter cleared at chip select fall and conversion start.
module adc_serial_timing_modes
    import adc_serial_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 csN,
    input  wire logic                 sckIn,
    output logic                      sckOut,
    output logic                      sckOe,
    output logic                      sckPullEn,
    input  wire logic                 sdi,
    output logic                      sdoOut,
    output logic                      sdoOe,
    input  wire logic                 oscSelectPinExt,
    input  wire logic                 convDone,
    input  wire logic [FRAME_BITS-1:0] convResult,
    output logic                      convStart,
    output logic [ADDR_BITS-1:0]      chanSel,
    output logic                      extMode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic [2:0]            pinRaw;
    logic [2:0]            s1_q, s2_q, s3_q, filt_q;
    logic                  csF, sckF, sdiF, csPrev_q, sckPrev_q;
    logic                  csFall, csRise, sckRise, sckFall;
    state_e                state_q;
    logic [CNT_W-1:0]      bitCnt_q;
    logic [DIV_W-1:0]      divCnt_q;
    logic [DLY_W-1:0]      dly_q;
    logic [POR_W-1:0]      porCnt_q;
    logic                  porDone_q;
    logic [FRAME_BITS-1:0] shift_q;
    logic [ADDR_BITS-1:0]  addrSh_q, chanSel_q;
    logic                  sckOut_q, sckOe_q, sckPullEn_q, reArm_q;
    logic                  sdoOut_q, sdoOe_q, convStart_q, extMode_q;
    logic                  extNow, rise, fall, firstRise, sample;
    logic [DLY_W-1:0]      testCyc;

    assign pinRaw = {csN, sckIn, sdi};

    // pins pass three flops; a level counts once stages two and three agree
    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q[i]   <= 1'b1;
                    s2_q[i]   <= 1'b1;
                    s3_q[i]   <= 1'b1;
                    filt_q[i] <= 1'b1;
                end else begin
                    s1_q[i] <= pinRaw[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    if (s2_q[i] == s3_q[i]) begin
                        filt_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate

    assign csF  = filt_q[2];
    assign sckF = filt_q[1];
    assign sdiF = filt_q[0];

    // previous filtered levels for edge detection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            csPrev_q  <= 1'b1;
            sckPrev_q <= 1'b1;
        end else begin
            csPrev_q  <= csF;
            sckPrev_q <= sckF;
        end
    end

    assign csFall  = csPrev_q & ~csF;
    assign csRise  = ~csPrev_q & csF;
    assign sckRise = ~sckPrev_q & sckF & ~csF;
    assign sckFall = sckPrev_q & ~sckF & ~csF;
    // mode is re-chosen on the very edge, so use the fresh choice at once
    assign extNow  = csFall ? ~sckF : extMode_q;
    // internal clock edges come from the divider phase
    assign rise = extMode_q ? sckRise : (divCnt_q == SCK_RISE_PH); // R22
    assign fall = extMode_q ? sckFall : (divCnt_q == SCK_FALL_PH); // R22
    assign firstRise = (state_q == ST_SLEEP) & extNow & sckRise
                       & ~csFall & porDone_q; // R06
    // input sampled only in the frame, never converting or deselected
    assign sample = firstRise | ((state_q == ST_DATA) & rise & ~csF); // R23
    assign testCyc = oscSelectPinExt ? TEST_EXT_CYC : TEST_INT_CYC;

    // power-on window; a strap-like level is caught at its end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            porCnt_q  <= '0;
            porDone_q <= 1'b0;
        end else if (!porDone_q) begin
            porCnt_q <= porCnt_q + 1'b1;
            if (porCnt_q >= POR_W'(POR_CYCLES - 1)) begin
                porDone_q <= 1'b1;
            end
        end
    end

    // clock mode: at power-on end and at every chip select fall after it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            extMode_q <= 1'b0;
        end else if (!porDone_q) begin
            if (porCnt_q >= POR_W'(POR_CYCLES - 1)) begin
                extMode_q <= ~sckF; // R12
            end
        end else if (csFall) begin
            extMode_q <= ~sckF; // R01 R02 R20
        end
    end
    AST_MODE_SEL: assert property (porDone_q && csFall
        |=> extMode_q == !$past(sckF)) // R01
        else $error("clock mode not taken from clock line at cs fall");

    // re-arm holds the pull-up on until the filtered line has come back
    // high; without it the stale low level switches the pull-up off again
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reArm_q <= 1'b0;
        end else if (state_q == ST_TEST && csRise) begin
            reArm_q <= 1'b1; // R21
        end else if (sckF || csFall) begin
            reArm_q <= 1'b0;
        end
    end

    // pull-up: off while line low, back on when polling ends early
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sckPullEn_q <= 1'b1;
        end else if (state_q == ST_TEST && csRise) begin
            sckPullEn_q <= 1'b1; // R21
        end else if (reArm_q) begin
            sckPullEn_q <= 1'b1; // R21
        end else if (!sckF) begin
            sckPullEn_q <= 1'b0; // R20
        end else begin
            sckPullEn_q <= 1'b1; // R02
        end
    end
    AST_PULLUP_BACK: assert property (state_q == ST_TEST && csRise
        |=> sckPullEn_q) // R21
        else $error("pull-up not restored after short status poll");

    // conversion cycle, frame counting and status test delay
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= ST_CONV;
            bitCnt_q    <= '0;
            divCnt_q    <= '0;
            dly_q       <= '0;
            convStart_q <= 1'b0;
        end else begin
            convStart_q <= 1'b0;
            divCnt_q    <= divCnt_q + 1'b1; // R22
            if (csFall) begin
                bitCnt_q <= '0; // R24
            end
            if (porDone_q) begin
                unique case (state_q)
                    ST_CONV: begin
                        if (convDone && !extMode_q && !csF) begin
                            state_q <= ST_TEST; // R15
                            dly_q   <= testCyc;
                        end else if (convDone) begin
                            state_q <= ST_SLEEP; // R05
                        end
                    end
                    ST_SLEEP: begin
                        if (csFall && sckF) begin
                            state_q <= ST_TEST; // R15
                            dly_q   <= testCyc;
                        end else if (firstRise) begin
                            state_q  <= ST_DATA; // R06
                            bitCnt_q <= 6'h01;
                        end
                    end
                    ST_TEST: begin
                        if (csRise) begin
                            state_q <= ST_SLEEP; // R16
                        end else if (dly_q <= DLY_ONE) begin
                            state_q  <= ST_DATA; // R15
                            divCnt_q <= SCK_RISE_PH;
                            bitCnt_q <= '0;
                        end else begin
                            dly_q <= dly_q - 1'b1;
                        end
                    end
                    ST_DATA: begin
                        if (csRise) begin
                            state_q     <= ST_CONV; // R10 R19
                            convStart_q <= 1'b1;
                            bitCnt_q    <= '0; // R24
                        end else if (!extMode_q && rise
                                     && bitCnt_q == LAST_RISE) begin
                            state_q     <= ST_CONV; // R18
                            convStart_q <= 1'b1;
                            bitCnt_q    <= '0; // R24
                        end else if (extMode_q && fall
                                     && bitCnt_q == FRAME_END) begin
                            state_q     <= ST_CONV; // R09
                            convStart_q <= 1'b1;
                            bitCnt_q    <= '0; // R24
                        end else if (rise) begin
                            bitCnt_q <= bitCnt_q + 1'b1; // R24
                        end
                    end
                endcase
            end
        end
    end
    AST_AUTO_SLEEP: assert property (state_q == ST_CONV && convDone
        && porDone_q && (extMode_q || csF) |=> state_q == ST_SLEEP) // R05
        else $error("finished conversion did not enter sleep");
    AST_SLEEP_HOLD: assert property (state_q == ST_SLEEP && csF
        |=> state_q == ST_SLEEP) // R06
        else $error("sleep left while chip select high");
    AST_EXT_START: assert property (extMode_q && state_q == ST_DATA
        && fall && bitCnt_q == FRAME_END && !csRise
        |=> convStart_q && state_q == ST_CONV ##1 sdoOut_q) // R09
        else $error("32nd falling edge did not start a conversion");
    AST_EXT_ABORT: assert property (extMode_q && state_q == ST_DATA
        && csRise |=> convStart_q && state_q == ST_CONV) // R10
        else $error("external frame abort did not start conversion");
    AST_INT_ABORT: assert property (!extMode_q && state_q == ST_DATA
        && csRise |=> convStart_q && state_q == ST_CONV) // R19
        else $error("internal frame abort did not start conversion");
    AST_TEST_WAIT: assert property (state_q == ST_TEST && !csRise
        && dly_q > DLY_ONE |=> state_q == ST_TEST) // R15
        else $error("status test delay cut short");
    AST_TEST_BACK: assert property (state_q == ST_TEST && csRise
        |=> state_q == ST_SLEEP) // R16
        else $error("short poll did not return to sleep");
    AST_INT_END: assert property (!extMode_q && state_q == ST_DATA
        && rise && bitCnt_q == LAST_RISE && !csRise
        |=> state_q == ST_CONV ##1 sckOut_q && sdoOut_q) // R18
        else $error("internal frame end did not hold clock and flag high");
    AST_CNT_CLEAR: assert property (convStart_q |-> bitCnt_q == '0) // R24
        else $error("frame counter not cleared at conversion start");

    // result register: load at end of conversion, shift on falling edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= '0;
        end else if (state_q == ST_CONV && convDone) begin
            shift_q <= convResult; // R13
        end else if (state_q == ST_DATA && fall && !csF) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], 1'b0}; // R07
        end
    end

    // channel address: committed only with its last bit, so a cut frame
    // leaves the old selection in place
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addrSh_q  <= '0;
            chanSel_q <= CHAN_RESET;
        end else if (sample) begin
            addrSh_q <= {addrSh_q[ADDR_BITS-2:0], sdiF}; // R07
            if (bitCnt_q == ADDR_LAST) begin
                chanSel_q <= {addrSh_q[ADDR_BITS-2:0], sdiF}; // R11
            end
        end
    end
    AST_ADDR_KEEP: assert property ($changed(chanSel_q)
        |-> $past(bitCnt_q) == ADDR_LAST && $past(sample)) // R11
        else $error("channel changed without full address");
    AST_SDI_IGNORE: assert property (csF || state_q == ST_CONV
        |=> $stable(addrSh_q)) // R23
        else $error("serial input taken while ignored");

    // pin drivers; the clock line is driven only in internal mode
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sdoOe_q  <= 1'b0;
            sdoOut_q <= 1'b1;
            sckOe_q  <= 1'b0;
            sckOut_q <= 1'b1;
        end else begin
            sdoOe_q <= ~csF; // R03
            unique case (state_q)
                ST_CONV:  sdoOut_q <= 1'b1; // R04
                ST_DATA:  sdoOut_q <= shift_q[FRAME_BITS-1]; // R07
                default:  sdoOut_q <= 1'b0; // R04
            endcase
            sckOe_q <= porDone_q & ~extMode_q & ~csF; // R14
            if (state_q == ST_DATA) begin
                if (rise) begin
                    sckOut_q <= 1'b1; // R22
                end else if (fall) begin
                    sckOut_q <= 1'b0; // R22
                end
            end else begin
                sckOut_q <= (state_q == ST_CONV); // R14 R18
            end
        end
    end
    AST_SDO_HIZ: assert property (csF |=> !sdoOe_q) // R03
        else $error("data output driven while deselected");
    AST_BUSY_FLAG: assert property (!csF && state_q == ST_CONV
        |=> sdoOut_q && sdoOe_q) // R04
        else $error("busy flag not shown while converting");

    COV_EXT_FRAME: cover property (extMode_q && state_q == ST_DATA
        && fall && bitCnt_q == FRAME_END);
    COV_INT_FRAME: cover property (!extMode_q && state_q == ST_DATA
        && rise && bitCnt_q == LAST_RISE);
    COV_SHORT_POLL: cover property (state_q == ST_TEST && csRise);
    COV_ABORT: cover property (state_q == ST_DATA && csRise);

    assign sckOut    = sckOut_q;
    assign sckOe     = sckOe_q;
    assign sckPullEn = sckPullEn_q;
    assign sdoOut    = sdoOut_q;
    assign sdoOe     = sdoOe_q;
    assign convStart = convStart_q;
    assign chanSel   = chanSel_q;
    assign extMode   = extMode_q;
endmodule : adc_serial_timing_modes

//--- tb/adc_host_model.sv
// host-side partner: clock and data wire resolution plus frame capture
module adc_host_model
    import adc_serial_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  csN,
    input  wire logic                  sckOut,
    input  wire logic                  sckOe,
    input  wire logic                  sckPullEn,
    input  wire logic                  sdoOut,
    input  wire logic                  sdoOe,
    input  wire logic                  hostSck,
    input  wire logic                  hostSckOe,
    output logic                       sckLine,
    output logic                       sdoLine,
    output logic [FRAME_BITS-1:0]      frameWord,
    output logic                       frameValid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic             sdoHeld_q = 1'b0;
    logic             sckPrev_q = 1'b0;
    logic [CNT_W-1:0] bitCnt_q  = '0;

    // undriven clock with the pull-up off stays low, which flips the mode
    always_comb begin
        if (sckOe)
            sckLine = sckOut;
        else if (hostSckOe)
            sckLine = hostSck;
        else
            sckLine = sckPullEn;
    end

    // released data line shows the inverse of its last driven value
    assign sdoLine = sdoOe ? sdoOut : ~sdoHeld_q;
    always_ff @(posedge mclk) begin
        if (sdoOe)
            sdoHeld_q <= sdoOut;
    end

    // latch on each clock rise: flag first, last result bit on the 32nd
    always_ff @(posedge mclk) begin
        sckPrev_q  <= sckLine;
        frameValid <= 1'b0;
        if (csN)
            bitCnt_q <= '0;
        else if (sckLine && !sckPrev_q) begin
            frameWord  <= {frameWord[FRAME_BITS-2:0], sdoLine};
            bitCnt_q   <= bitCnt_q + 1'b1;
            frameValid <= (bitCnt_q == LAST_RISE);
        end
    end
endmodule : adc_host_model

//--- tb/adc_serial_timing_modes_tb.sv
// self-checking bench for the converter serial interface
module adc_serial_timing_modes_tb
    import adc_serial_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int POR_SIM = 20;
    logic mclk = 1'b0, rst_n = 1'b0, csN = 1'b1, sdi = 1'b0;
    logic oscSelectPinExt = 1'b1, convDone = 1'b0;
    logic hostSck = 1'b0, hostSckOe = 1'b1;
    logic [FRAME_BITS-1:0] convResult = '0, lastWord, frameWord;
    logic [FRAME_BITS-1:0] expQ[$];
    logic sckLine, sckOut, sckOe, sckPullEn, sdoLine, sdoOut, sdoOe;
    logic convStart, extMode, frameValid;
    logic [ADDR_BITS-1:0] chanSel;
    int n_errors = 0;
    int n_checks = 0;
    int seed     = 62709;

    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    adc_serial_timing_modes #(.POR_CYCLES(POR_SIM)) dut (
        .mclk(mclk), .rst_n(rst_n), .csN(csN), .sckIn(sckLine),
        .sckOut(sckOut), .sckOe(sckOe), .sckPullEn(sckPullEn), .sdi(sdi),
        .sdoOut(sdoOut), .sdoOe(sdoOe), .oscSelectPinExt(oscSelectPinExt),
        .convDone(convDone), .convResult(convResult),
        .convStart(convStart), .chanSel(chanSel), .extMode(extMode));

    adc_host_model host (
        .mclk(mclk), .csN(csN), .sckOut(sckOut), .sckOe(sckOe),
        .sckPullEn(sckPullEn), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .hostSck(hostSck), .hostSckOe(hostSckOe), .sckLine(sckLine),
        .sdoLine(sdoLine), .frameWord(frameWord), .frameValid(frameValid));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // sample the one-cycle start pulse away from the launching edge
    task automatic wait_start(input int lim, output bit got);
        got = 1'b0;
        repeat (lim) begin
            @(negedge mclk);
            if (convStart === 1'b1)
                got = 1'b1;
        end
    endtask : wait_start

    // conversion core stand-in: one-cycle finished pulse with a new word
    task automatic conv_done();
        @(posedge mclk);
        lastWord = {1'b0, 31'($random(seed))};
        convResult <= lastWord;
        convDone   <= 1'b1;
        tick(1);
        convDone   <= 1'b0;
        tick(4);
    endtask : conv_done

    task automatic ext_frame(input int rises, input logic [7:0] addr);
        bit got;
        if (rises == 32)
            expQ.push_back(lastWord);
        @(posedge mclk);
        hostSckOe <= 1'b1;
        hostSck   <= 1'b0;
        tick(6);
        csN <= 1'b0;
        tick(10);
        check("extMode", extMode, 1);
        check("sdo sleep", sdoOut, 0);
        for (int i = 0; i < rises; i++) begin
            sdi <= (i < 8) ? addr[7 - i] : 1'($random(seed));
            tick(6);
            hostSck <= 1'b1;
            tick(6);
            hostSck <= 1'b0;
        end
        // a short frame is cut by chip select while the clock is low
        if (rises < 32) begin
            tick(3);
            csN <= 1'b1;
        end
        wait_start(20, got);
        check("convStart", got, 1);
        check("sdo busy", sdoOut, 1);
        tick(1);
        csN <= 1'b1;
        tick(8);
        check("sdo hiZ", sdoOe, 0);
    endtask : ext_frame

    task automatic int_frame(input bit full);
        bit got;
        int cnt;
        if (full)
            expQ.push_back(lastWord);
        @(posedge mclk);
        // lift the line first so the pull-up comes back before release
        hostSck <= 1'b1;
        sdi     <= 1'b1;
        tick(6);
        hostSckOe <= 1'b0;
        tick(6);
        csN <= 1'b0;
        tick(8);
        check("extMode", extMode, 0);
        check("sck drive", {sckOe, sckOut}, 2'b10);
        check("sdo flag", sdoOut, 0);
        if (!full) begin
            tick(40);
            csN <= 1'b1;
            tick(8);
            check("pull-up", sckPullEn, 1);
            wait_start(100, got);
            check("no start", got, 0);
        end else begin
            cnt = 0;
            while (sckOut !== 1'b1 && cnt < 4000) begin
                @(negedge mclk);
                cnt++;
            end
            check("delay", cnt + 12 >= TEST_EXT_CYC &&
                  cnt <= TEST_EXT_CYC + 4, 1);
            wait_start(32 * SCK_DIV + 20, got);
            check("convStart", got, 1);
            check("sck sdo", {sckOut, sdoOut}, 2'b11);
            check("chanSel", chanSel, 8'hFF);
            tick(1);
            csN <= 1'b1;
        end
        tick(8);
    endtask : int_frame

    // scoreboard: each captured frame against the oldest noted word
    always @(negedge mclk) begin
        if (frameValid === 1'b1)
            check("frame", frameWord,
                  expQ.size() > 0 ? expQ.pop_front() : 'x);
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // run is some 2100 cycles; about thirty times that means a hang
    initial begin
        #(60000 * CLK_PERIOD_NS);
        n_errors++;
        wrap_up();
    end

    initial begin
        tick(20);
        rst_n <= 1'b1;
        tick(POR_SIM + 10);
        check("extMode por", extMode, 1);
        check("sdo off", sdoOe, 0);
        conv_done();
        ext_frame(32, 8'hA5);
        check("chanSel", chanSel, 8'hA5);
        $display("test ext full done");
        conv_done();
        ext_frame(5, 8'h3C);
        check("chanSel kept", chanSel, 8'hA5);
        $display("test ext abort done");
        conv_done();
        int_frame(1'b1);
        $display("test int full done");
        conv_done();
        int_frame(1'b0);
        int_frame(1'b1);
        $display("test int poll done");
        wrap_up();
    end
endmodule : adc_serial_timing_modes_tb
